/* bench/audio_source.sv */
// Purpose: Far-side model driving the frame clock pin and per-channel zero-crossing pulses.
// Assumes: Bench requests a crossing by raising one zc_req bit for one cycle.
// Notes: Frame clock stands still low while run is low, like a stopped source.
`timescale 1ns/10ps
module audio_source #(
    parameter int FRAME_HALF = 4
) (
    input  wire logic       core_clk,
    input  wire logic       run,
    input  wire logic [7:0] zc_req,
    output logic            frame_clock,
    output logic [7:0]      zero_cross
);
    int cnt;

    // Frame clock toggles every FRAME_HALF cycles while running
    always_ff @(posedge core_clk)
    begin
        if (!run)
        begin
            frame_clock <= 1'b0;
            cnt         <= 0;
        end
        else if (cnt == FRAME_HALF - 1)
        begin
            frame_clock <= ~frame_clock;
            cnt         <= 0;
        end
        else
            cnt <= cnt + 1;
    end

    // One-cycle crossing pulses, independent per channel
    always_ff @(posedge core_clk)
        zero_cross <= zc_req;
endmodule // audio_source

/* bench/tb.sv */
// Purpose: Self-checking bench for the channel volume bank.
// Assumes: Timeout shortened to 4 frames so forced steps come quickly.
// Notes: Model keeps codes as integers; frames stop where only crossings may act.
`timescale 1ns/10ps
module tb;
    import volume_pkg::*;
    logic         core_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0, t;
    logic [7:0]   reg_addr = 8'h00, reg_wdata = 8'h00, zc_req = 8'h00, reg_rdata, zero_cross;
    logic         frame_clock, master_clock_halve, divided_clock_tick;
    level_s [7:0] channel_level;
    logic [15:0]  seed = 16'he558; // Start value 58712
    logic [9:0]   prev;
    int           n_mismatch = 0, checks_done = 0, cyc = 0, steps, last_step;
    int           code [8];
    logic [7:0]   amap [8] = '{8'h0b, 8'h0c, 8'h0e, 8'h0f, 8'h11, 8'h12, 8'h14, 8'h15};

    always #10 core_clk = ~core_clk;

    volume_bank #(.NUM_CHANNELS(8), .TIMEOUT_FRAMES(4)) dut (.core_clk(core_clk), .rst(rst),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .frame_clock(frame_clock), .zero_cross(zero_cross), .channel_level(channel_level),
        .master_clock_halve(master_clock_halve), .divided_clock_tick(divided_clock_tick));
    audio_source src (.core_clk(core_clk), .run(run), .zc_req(zc_req), .frame_clock(frame_clock),
        .zero_cross(zero_cross));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    // Settled level expected for a code: four eighths per half-dB step
    function automatic logic [10:0] lvl(input int c);
        return {1'b1, 10'(c * 4)};
    endfunction
    // One eighth toward the new code; bit 0 was flipped, so its value gives the direction
    function automatic logic [9:0] stepped(input logic [9:0] p, input int c);
        return p + ((c % 2) ? 10'h001 : 10'h3ff);
    endfunction
    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 check($sformatf("reg %h", a), reg_rdata, exp);
    endtask
    task automatic zc_pulse(input logic [7:0] m);
        @(posedge core_clk) zc_req <= m;
        @(posedge core_clk) zc_req <= 8'h00;
        repeat (5) @(posedge core_clk);
        #1;
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // Cycle ceiling cuts a hung run short
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            n_mismatch++;
            end_sim();
        end
    end

    // Main sequence
    initial
    begin
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(amap[i], 8'h00);
        rd(8'h16, 8'h00);
        rd(8'h19, 8'hff);
        $display("reset test done");
        // Random codes, deepest on the last channel; both modes off so levels jump
        for (int i = 0; i < 8; i++)
        begin
            seed = lfsr(seed);
            code[i] = (i == 7) ? 255 : int'(seed[7:0]);
            wr(amap[i], 8'(code[i]));
        end
        wr(8'h0d, 8'h55);
        wr(8'h19, 8'h00);
        repeat (3) @(posedge core_clk);
        for (int i = 0; i < 8; i++)
        begin
            rd(amap[i], 8'(code[i]));
            check("level", channel_level[i], lvl(code[i]));
        end
        rd(8'h0d, 8'h00);
        rd(8'h19, 8'hff);
        $display("direct test done");
        // Reserved clock mode bits are dropped; tick alternates only while halved
        wr(8'h16, 8'hff);
        rd(8'h16, 8'h20);
        t = divided_clock_tick;
        @(posedge core_clk) #1 check("tick", divided_clock_tick, !t);
        wr(8'h16, 8'h00);
        repeat (2) @(posedge core_clk);
        #1 check("tick", {master_clock_halve, divided_clock_tick}, 2'h1);
        $display("clock test done");
        // Soft ramp: exactly four single-eighth steps, one per frame
        wr(8'h18, 8'h01);
        run <= 1'b1;
        prev = channel_level[0].atten;
        code[0] = code[0] ^ 1;
        wr(amap[0], 8'(code[0]));
        steps = 0;
        for (int n = 0; n < 500 && channel_level[0] !== lvl(code[0]); n++)
        begin
            @(posedge core_clk) #1;
            if (channel_level[0].atten !== prev)
            begin
                steps++;
                check("step", channel_level[0].atten, stepped(prev, code[0]));
                if (steps > 1)
                    check("gap", 11'(n - last_step), 11'h008);
                last_step = n;
                prev = channel_level[0].atten;
            end
        end
        check("steps", 11'(steps), 11'h004);
        $display("soft test done");
        // Zero cross only: a crossing on channel 1 must not move channel 2
        run <= 1'b0;
        wr(8'h18, 8'h02);
        prev = channel_level[2].atten;
        code[1] = code[1] ^ 16;
        code[2] = code[2] ^ 16;
        wr(amap[1], 8'(code[1]));
        wr(amap[2], 8'(code[2]));
        repeat (20) @(posedge core_clk);
        zc_pulse(8'h02);
        check("zc jump", channel_level[1], lvl(code[1]));
        check("zc other", channel_level[2].atten, prev);
        run <= 1'b1;
        for (int n = 0; n < 300 && channel_level[2] !== lvl(code[2]); n++) @(posedge core_clk) #1;
        check("zc timeout", channel_level[2], lvl(code[2]));
        // Both modes: one crossing gives one eighth step
        run <= 1'b0;
        wr(8'h18, 8'h03);
        prev = channel_level[3].atten;
        code[3] = code[3] ^ 1;
        wr(amap[3], 8'(code[3]));
        zc_pulse(8'h08);
        check("zc step", channel_level[3].atten, stepped(prev, code[3]));
        $display("zero cross test done");
        end_sim();
    end
endmodule // tb

/* bench/volume_bank_monitor.sv */
// Purpose: Port-level assertions for the channel volume bank.
// Assumes: One clock domain with synchronous active-high reset.
// Notes: Channels 0 and 7 stand in for the rest to keep the checker small.
`timescale 1ns/10ps
module volume_bank_monitor #(
    parameter int NUM_CHANNELS   = 8,
    parameter int TIMEOUT_FRAMES = 512
) (
    input wire logic                             core_clk,
    input wire logic                             rst,
    input wire logic [7:0]                       reg_addr,
    input wire logic [7:0]                       reg_wdata,
    input wire logic                             reg_wr,
    input wire logic                             reg_rd,
    input wire logic [7:0]                       reg_rdata,
    input wire logic                             frame_clock,
    input wire logic [NUM_CHANNELS-1:0]          zero_cross,
    input volume_pkg::level_s [NUM_CHANNELS-1:0] channel_level,
    input wire logic                             master_clock_halve,
    input wire logic                             divided_clock_tick
);
    import volume_pkg::*;
    // Single domain, so clock and reset are stated once
    default clocking @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_unmapped; reg_rd && reg_addr == 8'h0d |=> reg_rdata == 8'h00; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
    property p_halve_wr; reg_wr && reg_addr == 8'h16 |=> master_clock_halve == $past(reg_wdata[5]); endproperty
    a_halve_wr: assert property (p_halve_wr) else $error("halve bit not stored");
    property p_mode_rd; reg_rd && reg_addr == 8'h16 |=> reg_rdata == {2'h0, $past(master_clock_halve), 5'h00};
    endproperty
    a_mode_rd: assert property (p_mode_rd) else $error("clock mode readback wrong");
    property p_tick_full; !master_clock_halve && !$past(master_clock_halve) |-> divided_clock_tick; endproperty
    a_tick_full: assert property (p_tick_full) else $error("tick gated while undivided");
    // Three halved cycles in a row guarantee the divider has started
    property p_tick_half;
        master_clock_halve && $past(master_clock_halve) && $past(master_clock_halve, 2)
            |-> divided_clock_tick != $past(divided_clock_tick);
    endproperty
    a_tick_half: assert property (p_tick_half) else $error("tick not halved");
    property p_hold;
        channel_level[0].settled && $past(channel_level[0].settled) && !reg_wr && !$past(reg_wr)
            && !$past(reg_wr, 2) |=> $stable(channel_level[0].atten);
    endproperty
    a_hold: assert property (p_hold) else $error("settled level moved");
    property p_align; channel_level[7].settled |-> channel_level[7].atten[1:0] == 2'h0; endproperty
    a_align: assert property (p_align) else $error("settled level off code grid");
    property p_max; channel_level[7].atten <= 10'h3fc; endproperty
    a_max: assert property (p_max) else $error("level beyond deepest code");

    c_halved: cover property (master_clock_halve && !divided_clock_tick);
    c_ramp: cover property (!channel_level[0].settled);
    c_deep: cover property (channel_level[7].atten == 10'h3fc);
endmodule // volume_bank_monitor

bind volume_bank volume_bank_monitor #(.NUM_CHANNELS(NUM_CHANNELS), .TIMEOUT_FRAMES(TIMEOUT_FRAMES)) mon (
    .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .frame_clock(frame_clock), .zero_cross(zero_cross),
    .channel_level(channel_level), .master_clock_halve(master_clock_halve),
    .divided_clock_tick(divided_clock_tick));

/* verilog/volume_bank.sv */
// Purpose: Eight channel volume registers, clock mode register and per-channel level ramps.
// Assumes: Register port and zero-cross pulses are on core_clk; frame_clock is a pin.
// Notes: The halved master clock is carried as a tick that gates every internal step.
//
// The strobed register port is this design's own decision.
`timescale 1ns/10ps
`include "volume_defines.svh"
module volume_bank #(
    parameter int NUM_CHANNELS   = 8,
    parameter int TIMEOUT_FRAMES = `ZC_TIMEOUT_FRAMES
) (
    input  wire logic                          core_clk,
    input  wire logic                          rst,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    output logic [7:0]                         reg_rdata,
    input  wire logic                          frame_clock,
    input  wire logic [NUM_CHANNELS-1:0]       zero_cross,
    output volume_pkg::level_s [NUM_CHANNELS-1:0] channel_level,
    output logic                               master_clock_halve,
    output logic                               divided_clock_tick
);
    import volume_pkg::*;

    logic [7:0]              volume_code [NUM_CHANNELS];
    logic [NUM_CHANNELS-1:0] volume_hit;
    ramp_cfg_s               ramp_cfg;
    logic                    frame_meta;
    logic                    frame_sync;
    logic                    frame_prev;
    logic                    frame_edge;
    logic                    frame_pending;
    logic [NUM_CHANNELS-1:0] zero_pending;
    logic [7:0]              read_value;
    logic [7:0]              status_value;

    // Register address of each channel, first then second of each pair
    function automatic logic [7:0] channel_addr(input int ch);
        logic [7:0] a;
        a = 8'h00;
        case (ch)
            0:       a = `ADDR_PAIR1_FIRST;
            1:       a = `ADDR_PAIR1_SECOND;
            2:       a = `ADDR_PAIR2_FIRST;
            3:       a = `ADDR_PAIR2_SECOND;
            4:       a = `ADDR_PAIR3_FIRST;
            5:       a = `ADDR_PAIR3_SECOND;
            6:       a = `ADDR_PAIR4_FIRST;
            7:       a = `ADDR_PAIR4_SECOND;
            default: a = 8'h00;
        endcase
        return a;
    endfunction

    // Clock mode: only the halve bit is stored, so reserved bits cannot stick
    always_ff @(posedge core_clk)
    begin
        if (rst)
            master_clock_halve <= 1'(`CLOCK_MODE_RESET >> `HALVE_BIT);
        else if (reg_wr && reg_addr == `ADDR_CLOCK_MODE)
            master_clock_halve <= reg_wdata[`HALVE_BIT];
    end

    // Internal clock tick: every cycle undivided, every second cycle halved
    always_ff @(posedge core_clk)
    begin
        if (rst)
            divided_clock_tick <= 1'b1;
        else if (master_clock_halve)
            divided_clock_tick <= ~divided_clock_tick;
        else
            divided_clock_tick <= 1'b1;
    end

    // Ramp behaviour controls
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            ramp_cfg.soft_ramp  <= 1'b0;
            ramp_cfg.zero_cross <= 1'b0;
        end
        else if (reg_wr && reg_addr == `ADDR_RAMP_CONTROL)
        begin
            ramp_cfg.soft_ramp  <= reg_wdata[`SOFT_RAMP_BIT];
            ramp_cfg.zero_cross <= reg_wdata[`ZERO_CROSS_BIT];
        end
    end

    // Frame clock comes from a pin: two flops before anything looks at it
    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            frame_meta <= 1'b0;
            frame_sync <= 1'b0;
            frame_prev <= 1'b0;
        end
        else
        begin
            frame_meta <= frame_clock;
            frame_sync <= frame_meta;
            frame_prev <= frame_sync;
        end
    end

    assign frame_edge = frame_sync && !frame_prev;

    // Hold a frame edge until a tick consumes it, so halving never loses one;
    // an edge that meets a tick is used at once and must not count twice
    always_ff @(posedge core_clk)
    begin
        if (rst)
            frame_pending <= 1'b0;
        else if (frame_edge && !divided_clock_tick)
            frame_pending <= 1'b1;
        else if (divided_clock_tick)
            frame_pending <= 1'b0;
    end

    // Per-channel registers, crossing capture and ramp
    genvar g;
    generate
        for (g = 0; g < NUM_CHANNELS; g++)
        begin : chan
            assign volume_hit[g] = (reg_addr == channel_addr(g));

            // Volume code; each channel written on its own address only
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    volume_code[g] <= `VOLUME_RESET;
                else if (reg_wr && volume_hit[g])
                    volume_code[g] <= reg_wdata;
            end

            // Crossing held until a tick sees it; one that meets a tick is used at once
            always_ff @(posedge core_clk)
            begin
                if (rst)
                    zero_pending[g] <= 1'b0;
                else if (zero_cross[g] && !divided_clock_tick)
                    zero_pending[g] <= 1'b1;
                else if (divided_clock_tick)
                    zero_pending[g] <= 1'b0;
            end

            volume_ramp #(
                .TIMEOUT_FRAMES (TIMEOUT_FRAMES)
            ) ramp (
                .core_clk    (core_clk),
                .rst         (rst),
                .step_enable (divided_clock_tick),
                .frame_event (frame_pending || frame_edge),
                .zero_event  (zero_pending[g] || zero_cross[g]),
                .target_code (volume_code[g]),
                .cfg         (ramp_cfg),
                .level       (channel_level[g])
            );
        end
    endgenerate

    // Which channels have reached their programmed level
    always_comb
    begin
        status_value = 8'h00;
        for (int i = 0; i < NUM_CHANNELS && i < 8; i++)
            status_value[i] = channel_level[i].settled;
    end

    // Read mux; unmapped addresses and reserved bits read zero
    always_comb
    begin
        read_value = 8'h00;
        for (int i = 0; i < NUM_CHANNELS; i++)
            if (volume_hit[i])
                read_value = volume_code[i];
        case (reg_addr)
            `ADDR_CLOCK_MODE:   read_value = 8'(master_clock_halve) << `HALVE_BIT;
            `ADDR_RAMP_CONTROL: read_value = {6'h00, ramp_cfg.zero_cross, ramp_cfg.soft_ramp};
            `ADDR_LEVEL_STATUS: read_value = status_value;
            default:            read_value = read_value;
        endcase
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge core_clk)
    begin
        if (rst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= read_value;
        else
            reg_rdata <= 8'h00;
    end

endmodule // volume_bank

/* verilog/volume_defines.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the channel volume bank.
// Assumes: Byte-wide register port; one frame clock period equals one sample period.
// Notes: Attenuation is carried internally in eighth-dB units, four per code step.
// How it works
// - Eight independent volume registers, one per output channel, each with its own level.
// - Channels sit at 0b/0c, 0e/0f, 11/12, 14/15: first then second of each pair.
// - Eight-bit code, half-dB steps, 00 is 0 dB default, 255 is deepest setting.
// - Attenuation equals code times 6.02/12 dB; printed dB values are approximate.
// - A new code takes effect through soft ramp and zero-cross settings; with both off it applies as one step.
// - With the halve bit set, the master clock is divided by two for the level ramps only.
// - With the halve bit clear, its default, the master clock passes undivided.
// - Soft ramp moves one eighth dB at a time, 1 dB per 8 frame periods.
// - Zero-cross gating waits for a crossing, forced after 512 to 1024 sample periods.
// - Zero crossings and level steps are tracked separately for each channel.
`ifndef VOLUME_DEFINES_SVH
`define VOLUME_DEFINES_SVH

`define ADDR_PAIR1_FIRST   8'h0b
`define ADDR_PAIR1_SECOND  8'h0c
`define ADDR_PAIR2_FIRST   8'h0e
`define ADDR_PAIR2_SECOND  8'h0f
`define ADDR_PAIR3_FIRST   8'h11
`define ADDR_PAIR3_SECOND  8'h12
`define ADDR_PAIR4_FIRST   8'h14
`define ADDR_PAIR4_SECOND  8'h15
`define ADDR_CLOCK_MODE    8'h16
`define ADDR_RAMP_CONTROL  8'h18
`define ADDR_LEVEL_STATUS  8'h19

`define VOLUME_RESET       8'h00
`define CLOCK_MODE_RESET   8'h00
`define RAMP_CONTROL_RESET 8'h00
`define HALVE_BIT          5
`define SOFT_RAMP_BIT      0
`define ZERO_CROSS_BIT     1

`define ZC_TIMEOUT_FRAMES  512
`define ZC_TIMEOUT_MAX     1024

`endif

/* verilog/volume_pkg.sv */
// Purpose: Types shared by the volume bank and its per-channel ramp.
// Assumes: Eighth-dB attenuation fits ten bits (255 codes times four).
// Notes: Numeric constants live in volume_defines.svh.
package volume_pkg;

    typedef logic [9:0] eighths_t;

    // How a code change reaches the output level
    typedef struct packed {
        logic soft_ramp;
        logic zero_cross;
    } ramp_cfg_s;

    // Applied level of one channel
    typedef struct packed {
        logic     settled;
        eighths_t atten;
    } level_s;

    typedef enum logic {
        CH_SETTLED,
        CH_MOVING
    } ramp_state_e;

endpackage

/* verilog/volume_ramp.sv */
// Purpose: Moves one channel's applied attenuation toward its programmed code.
// Assumes: Events arrive unqualified; step_enable carries the divided clock tick.
// Notes: Timeout counts frames since the last step or crossing.
`timescale 1ns/10ps
`include "volume_defines.svh"
module volume_ramp #(
    parameter int TIMEOUT_FRAMES = `ZC_TIMEOUT_FRAMES
) (
    input  wire logic               core_clk,
    input  wire logic               rst,
    input  wire logic               step_enable,
    input  wire logic               frame_event,
    input  wire logic               zero_event,
    input  wire logic [7:0]         target_code,
    input  volume_pkg::ramp_cfg_s   cfg,
    output volume_pkg::level_s      level
);
    import volume_pkg::*;

    eighths_t    target;
    eighths_t    current;
    eighths_t    next_current;
    logic [9:0]  timeout_count;
    logic        timeout_hit;
    logic        step_ok;
    ramp_state_e state;

    // Each code step is four eighth-dB steps
    assign target = {target_code, 2'b00};
    assign timeout_hit = frame_event && (timeout_count >= 10'(TIMEOUT_FRAMES - 1));

    // Decide whether a step may be taken in this tick
    always_comb
    begin
        step_ok = 1'b0;
        if (step_enable)
        begin
            if (cfg.zero_cross)
                step_ok = zero_event || timeout_hit;
            else if (cfg.soft_ramp)
                step_ok = frame_event;
            else
                step_ok = 1'b1;
        end
    end

    // Soft ramp walks by one eighth dB; otherwise jump straight to target
    always_comb
    begin
        next_current = current;
        if (step_ok && current != target)
        begin
            if (!cfg.soft_ramp)
                next_current = target;
            else if (current < target)
                next_current = current + 10'd1;
            else
                next_current = current - 10'd1;
        end
    end

    // Applied level
    always_ff @(posedge core_clk)
    begin
        if (rst)
            current <= 10'h000;
        else
            current <= next_current;
    end

    // Frames since the last step; a crossing or a settled level restarts the wait,
    // so a forced step never comes early after a new code
    always_ff @(posedge core_clk)
    begin
        if (rst)
            timeout_count <= 10'h000;
        else if (step_enable && (zero_event || timeout_hit))
            timeout_count <= 10'h000;
        else if (current == target)
            timeout_count <= 10'h000;
        else if (step_enable && frame_event)
            timeout_count <= timeout_count + 10'd1;
    end

    // Settled or moving
    always_ff @(posedge core_clk)
    begin
        if (rst)
            state <= CH_SETTLED;
        else
        begin
            case (state)
                CH_SETTLED: if (target != current) state <= CH_MOVING;
                CH_MOVING:  if (next_current == target) state <= CH_SETTLED;
                default:    state <= CH_SETTLED;
            endcase
        end
    end

    assign level.settled = (state == CH_SETTLED);
    assign level.atten   = current;

endmodule // volume_ramp
